// ===== hw/acs_pkg.sv
// Constants, register map and state type of the converter sequencer.
// Assumes an APB master with 32-bit data; each register takes one aligned word.
// Behaviour
// - Start write converts the selected channel
// - Start bit clears itself after acceptance
// - Finish only after selected conversion time
// - Result, done flag, interrupt in one step
// - Result is eight bits
// - Reading result clears done flag
// - Restart clears done, old result kept
// - STOP aborts without done or interrupt
// - STOP resets both control registers
// - STOP discards stored result
// - No automatic resume after STOP
// - STOP disconnects the ladder
// - Time codes give 78, 156, 312 cycles
// - Busy set on start, cleared on finish/STOP
package acs_pkg;

	// ****************************************
	// Register indices, byte address is four times the index
	// ****************************************
	localparam logic [9:0] ACS_IDX_CTRL_ONE  = 10'h00e;
	localparam logic [9:0] ACS_IDX_CTRL_TWO  = 10'h00f;
	localparam logic [9:0] ACS_IDX_RESULT    = 10'h020;
	localparam logic [9:0] ACS_IDX_STATUS    = 10'h021;
	localparam logic [9:0] ACS_IDX_IRQ_STAT  = 10'h030;
	localparam logic [9:0] ACS_IDX_IRQ_CLEAR = 10'h031;
	localparam logic [9:0] ACS_IDX_IRQ_EN    = 10'h032;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int         ACS_C1_START     = 7;
	localparam int         ACS_C1_AIN_DIS   = 4;
	localparam int         ACS_C2_LADDER    = 5;
	localparam int         ACS_C2_TIME_LO   = 1;
	localparam int         ACS_ST_DONE      = 5;
	localparam int         ACS_ST_BUSY      = 4;
	localparam logic [6:0] ACS_CTRL_ONE_RST = 7'h10;
	localparam logic [5:0] ACS_CTRL_TWO_RST = 6'h00;
	localparam logic [7:0] ACS_RESULT_RST   = 8'h00;

	// ****************************************
	// Conversion time codes and cycle counts
	// ****************************************
	localparam logic [2:0] ACS_TIME_78   = 3'h2;
	localparam logic [2:0] ACS_TIME_156  = 3'h3;
	localparam logic [2:0] ACS_TIME_312  = 3'h4;
	localparam logic [8:0] ACS_CYC_78    = 9'h04e;
	localparam logic [8:0] ACS_CYC_156   = 9'h09c;
	localparam logic [8:0] ACS_CYC_312   = 9'h138;
	localparam logic [8:0] ACS_STEP_HI   = 9'h00a;
	localparam logic [8:0] ACS_STEP_LO   = 9'h002;
	localparam logic [8:0] ACS_CNT_LAST  = 9'h001;

	typedef enum logic [1:0] {
		ACS_IDLE = 2'h0,
		ACS_CONV = 2'h1
	} acs_state_t;

endpackage

// ===== hw/acs_conv_timer.sv
// Conversion time down counter with successive approximation step window.
// Assumes load is a one-cycle request from the sequencer; abort is the STOP input, held while STOP lasts.
`timescale 1ns/1ps
module acs_conv_timer (
	input  wire logic       mclk_i,
	input  wire logic       rst_b_i,
	input  wire logic       load_i,
	input  wire logic       abort_i,
	input  wire logic [8:0] count_i,
	output logic            step_o,
	output logic            expire_o
);

	typedef struct packed {
		logic [8:0] cnt;
		logic       run;
	} acs_tmr_t;

	acs_tmr_t q;
	acs_tmr_t d;

	always_comb begin
		d = q;
		if (abort_i) begin
			d.run = 1'b0;
		end else if (load_i) begin
			d.cnt = count_i;
			d.run = 1'b1;
		end else if (q.run) begin
			d.cnt = q.cnt - 9'h001;
			if (q.cnt == acs_pkg::ACS_CNT_LAST) begin
				d.run = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Nine trials end one cycle before expiry so the code is settled when captured
	assign step_o   = q.run && !abort_i && (q.cnt >= acs_pkg::ACS_STEP_LO)
	                  && (q.cnt <= acs_pkg::ACS_STEP_HI);
	assign expire_o = q.run && !abort_i && (q.cnt == acs_pkg::ACS_CNT_LAST);

endmodule

// ===== hw/acs_sar.sv
// Successive approximation register: one trial per step pulse, nine steps.
// Assumes the comparator answers for the driven code within one cycle.
`timescale 1ns/1ps
module acs_sar (
	input  wire logic       mclk_i,
	input  wire logic       rst_b_i,
	input  wire logic       load_i,
	input  wire logic       step_i,
	input  wire logic       comp_hi_i,
	output logic [7:0]      code_o
);

	typedef struct packed {
		logic [7:0] code;
		logic [7:0] mask;
	} acs_sar_t;

	acs_sar_t q;
	acs_sar_t d;

	always_comb begin
		d = q;
		if (load_i) begin
			d.code = 8'h00;
			d.mask = 8'h00;
		end else if (step_i) begin
			if (q.mask == 8'h00) begin
				d.code = 8'h80;
				d.mask = 8'h80;
			end else begin
				// Drop the trial bit when the input lies below the trial level
				if (!comp_hi_i) begin
					d.code = q.code & ~q.mask;
				end
				d.mask = q.mask >> 1;
				d.code = d.code | d.mask;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign code_o = q.code;

endmodule

// ===== hw/acs_adc_seq.sv
// Converter sequencer top: APB register file, start and STOP handling, interrupts.
// Assumes mclk_i is the high-frequency clock and stop_mode_i is synchronous.
`timescale 1ns/1ps
module acs_adc_seq (
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic             pready_o,
	output logic [31:0]      prdata_o,
	output logic             pslverr_o,
	input  wire logic        stop_mode_i,
	input  wire logic        comp_hi_i,
	output logic [7:0]       dac_code_o,
	output logic [3:0]       channel_select_o,
	output logic             analog_input_disable_o,
	output logic             ladder_connect_o,
	output logic             busy_o,
	output logic             conv_done_irq_o,
	output logic             irq_o
);

	typedef struct packed {
		acs_pkg::acs_state_t state;
		logic                start;
		logic [6:0]          ctrl_one;
		logic [5:0]          ctrl_two;
		logic [7:0]          result;
		logic                done;
		logic                done_pulse;
		logic                ladder;
		logic                irq_stat;
		logic                irq_en;
		logic [31:0]         rdata;
		logic                err;
	} acs_top_t;

	acs_top_t   q;
	acs_top_t   d;
	logic       setup;
	logic       wr_acc;
	logic       rd_acc;
	logic       hit;
	logic [9:0] idx;
	logic       accept;
	logic       step;
	logic       expire;
	logic [8:0] conv_cycles;
	logic [7:0] sar_code;

	// ****************************************
	// APB decode
	// ****************************************
	assign idx    = paddr_i[11:2];
	assign setup  = psel_i && !penable_i;
	assign wr_acc = psel_i && penable_i && pwrite_i;
	assign rd_acc = psel_i && penable_i && !pwrite_i;

	always_comb begin
		hit = 1'b1;
		if (idx == acs_pkg::ACS_IDX_CTRL_ONE) begin
			hit = 1'b1;
		end else if (idx == acs_pkg::ACS_IDX_CTRL_TWO) begin
			hit = 1'b1;
		end else if (idx == acs_pkg::ACS_IDX_RESULT) begin
			hit = 1'b1;
		end else if (idx == acs_pkg::ACS_IDX_STATUS) begin
			hit = 1'b1;
		end else if (idx == acs_pkg::ACS_IDX_IRQ_STAT) begin
			hit = 1'b1;
		end else if (idx == acs_pkg::ACS_IDX_IRQ_CLEAR) begin
			hit = 1'b1;
		end else if (idx == acs_pkg::ACS_IDX_IRQ_EN) begin
			hit = 1'b1;
		end else begin
			hit = 1'b0;
		end
	end

	// ****************************************
	// Conversion time select
	// ****************************************
	// Reserved codes fall back to the longest time rather than refusing the start
	always_comb begin
		case (q.ctrl_two[acs_pkg::ACS_C2_TIME_LO +: 3])
			acs_pkg::ACS_TIME_78:  conv_cycles = acs_pkg::ACS_CYC_78;
			acs_pkg::ACS_TIME_156: conv_cycles = acs_pkg::ACS_CYC_156;
			acs_pkg::ACS_TIME_312: conv_cycles = acs_pkg::ACS_CYC_312;
			default:               conv_cycles = acs_pkg::ACS_CYC_312;
		endcase
	end

	// A pending start is taken only when idle; a start while converting is dropped
	assign accept = q.start && (q.state == acs_pkg::ACS_IDLE) && !stop_mode_i;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		d            = q;
		d.done_pulse = 1'b0;
		d.err        = 1'b0;

		// Read data is captured in the setup cycle so the access phase sees a flop
		if (setup && !pwrite_i) begin
			d.rdata = 32'h0000_0000;
			d.err   = !hit;
			if (idx == acs_pkg::ACS_IDX_CTRL_ONE) begin
				d.rdata[6:0] = q.ctrl_one;
			end else if (idx == acs_pkg::ACS_IDX_CTRL_TWO) begin
				d.rdata[5:0] = q.ctrl_two;
			end else if (idx == acs_pkg::ACS_IDX_RESULT) begin
				d.rdata[7:0] = q.result;
			end else if (idx == acs_pkg::ACS_IDX_STATUS) begin
				d.rdata[acs_pkg::ACS_ST_DONE] = q.done;
				d.rdata[acs_pkg::ACS_ST_BUSY] = (q.state == acs_pkg::ACS_CONV);
			end else if (idx == acs_pkg::ACS_IDX_IRQ_STAT) begin
				d.rdata[0] = q.irq_stat;
			end else if (idx == acs_pkg::ACS_IDX_IRQ_EN) begin
				d.rdata[0] = q.irq_en;
			end
		end else if (setup) begin
			d.err = !hit;
		end

		// Register writes
		if (wr_acc) begin
			if (idx == acs_pkg::ACS_IDX_CTRL_ONE) begin
				d.ctrl_one = pwdata_i[6:0];
				d.start    = pwdata_i[acs_pkg::ACS_C1_START];
			end else if (idx == acs_pkg::ACS_IDX_CTRL_TWO) begin
				d.ctrl_two = pwdata_i[5:0];
			end else if (idx == acs_pkg::ACS_IDX_IRQ_CLEAR) begin
				if (pwdata_i[0]) begin
					d.irq_stat = 1'b0;
				end
			end else if (idx == acs_pkg::ACS_IDX_IRQ_EN) begin
				d.irq_en = pwdata_i[0];
			end
		end

		// Result read clears the done flag; a completion in the same cycle wins below
		if (rd_acc && (idx == acs_pkg::ACS_IDX_RESULT)) begin
			d.done = 1'b0;
		end

		// Start bit never survives past the cycle after it was written
		if (q.start) begin
			d.start = 1'b0;
		end

		case (q.state)
			acs_pkg::ACS_IDLE: begin
				if (accept) begin
					d.state = acs_pkg::ACS_CONV;
					d.done  = 1'b0;
				end
			end
			acs_pkg::ACS_CONV: begin
				if (expire) begin
					d.state      = acs_pkg::ACS_IDLE;
					d.result     = sar_code;
					d.done       = 1'b1;
					d.done_pulse = 1'b1;
					d.irq_stat   = 1'b1;
				end
			end
			default: begin
				d.state = acs_pkg::ACS_IDLE;
			end
		endcase

		// STOP overrides the state, start, done, control and result updates above and blocks writes other than to the interrupt enable while it lasts
		if (stop_mode_i) begin
			d.state      = acs_pkg::ACS_IDLE;
			d.start      = 1'b0;
			d.done       = 1'b0;
			d.done_pulse = 1'b0;
			d.irq_stat   = q.irq_stat;
			d.ctrl_one   = acs_pkg::ACS_CTRL_ONE_RST;
			d.ctrl_two   = acs_pkg::ACS_CTRL_TWO_RST;
			d.result     = acs_pkg::ACS_RESULT_RST;
		end

		// Ladder follows the always-on option, else only while converting
		d.ladder = !stop_mode_i && (d.ctrl_two[acs_pkg::ACS_C2_LADDER]
		           || (d.state == acs_pkg::ACS_CONV));
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q          <= '0;
			q.state    <= acs_pkg::ACS_IDLE;
			q.ctrl_one <= acs_pkg::ACS_CTRL_ONE_RST;
			q.ctrl_two <= acs_pkg::ACS_CTRL_TWO_RST;
			q.result   <= acs_pkg::ACS_RESULT_RST;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Timing and approximation
	// ****************************************
	acs_conv_timer u_timer (
		.mclk_i   (mclk_i),
		.rst_b_i  (rst_b_i),
		.load_i   (accept),
		.abort_i  (stop_mode_i),
		.count_i  (conv_cycles),
		.step_o   (step),
		.expire_o (expire)
	);

	acs_sar u_sar (
		.mclk_i    (mclk_i),
		.rst_b_i   (rst_b_i),
		.load_i    (accept),
		.step_i    (step),
		.comp_hi_i (comp_hi_i),
		.code_o    (sar_code)
	);

	// ****************************************
	// Outputs
	// ****************************************
	assign pready_o               = 1'b1;
	assign prdata_o               = q.rdata;
	assign pslverr_o              = psel_i && penable_i && q.err;
	assign dac_code_o             = sar_code;
	assign channel_select_o       = q.ctrl_one[3:0];
	assign analog_input_disable_o = q.ctrl_one[acs_pkg::ACS_C1_AIN_DIS];
	assign ladder_connect_o       = q.ladder;
	assign busy_o                 = (q.state == acs_pkg::ACS_CONV);
	assign conv_done_irq_o        = q.done_pulse;
	assign irq_o                  = q.irq_stat && q.irq_en;

endmodule

// ===== dv/acs_ain_model.sv
// Analog source and comparator seen by the sequencer.
// Assumes each channel level is fixed while a conversion runs.
`timescale 1ns/1ps
module acs_ain_model (
	input  wire logic [3:0] channel_select_i,
	input  wire logic [7:0] dac_code_i,
	input  wire logic       ladder_i,
	output logic            comp_hi_o
);
	// ****
	// Comparator
	// ****
	logic [7:0] level;
	assign level = 8'h17 * channel_select_i + 8'h05;
	// No reference without the ladder, so the answer toggles with the code
	assign comp_hi_o = ladder_i ? (level >= dac_code_i) : ~dac_code_i[0];
endmodule

// ===== dv/acs_adc_seq_sva.sv
// Port checker for the converter sequencer.
// Assumes a single clock domain on mclk_i.
`timescale 1ns/1ps
module acs_adc_seq_sva (
	input wire logic        mclk_i,
	input wire logic        rst_b_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic        pslverr_o,
	input wire logic        stop_mode_i,
	input wire logic [3:0]  channel_select_o,
	input wire logic        analog_input_disable_o,
	input wire logic        ladder_connect_o,
	input wire logic        busy_o,
	input wire logic        conv_done_irq_o
);
	// ****
	// Helpers and assertions
	// ****
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	logic       wr_start;
	logic [8:0] run_q;
	logic       mapped;
	assign mapped = paddr_i[11:2] inside {acs_pkg::ACS_IDX_CTRL_ONE, acs_pkg::ACS_IDX_CTRL_TWO,
		acs_pkg::ACS_IDX_RESULT, acs_pkg::ACS_IDX_STATUS, acs_pkg::ACS_IDX_IRQ_STAT,
		acs_pkg::ACS_IDX_IRQ_CLEAR, acs_pkg::ACS_IDX_IRQ_EN};
	assign wr_start = psel_i && penable_i && pwrite_i && pwdata_i[7]
		&& paddr_i[11:2] == acs_pkg::ACS_IDX_CTRL_ONE;
	// Busy length is the conversion time actually spent
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			run_q <= 9'h000;
		else
			run_q <= busy_o ? run_q + 9'h001 : 9'h000;
	end
	sequence accepted_start;
		wr_start && !busy_o && !stop_mode_i ##1 !stop_mode_i;
	endsequence
	sequence stays_idle;
		!busy_o [*2];
	endsequence
	start_busy_a: assert property (accepted_start |-> ##1 busy_o)
		else $error("accepted start did not raise busy");
	busy_cause_a: assert property ($rose(busy_o) |-> $past(wr_start, 2))
		else $error("busy rose without a start write");
	conv_time_a: assert property (conv_done_irq_o |-> run_q inside {9'h04e, 9'h09c, 9'h138})
		else $error("conversion time is not a legal count");
	irq_pulse_a: assert property (conv_done_irq_o |=> !conv_done_irq_o)
		else $error("done interrupt longer than one cycle");
	done_ends_busy_a: assert property (conv_done_irq_o |-> !busy_o && $past(busy_o))
		else $error("done pulse not at end of busy");
	stop_abort_a: assert property (stop_mode_i |=> !busy_o && !conv_done_irq_o)
		else $error("stop did not abort quietly");
	stop_ctrl_a: assert property (stop_mode_i |=>
		channel_select_o == 4'h0 && analog_input_disable_o)
		else $error("stop did not reset controls");
	stop_ladder_a: assert property (stop_mode_i |=> !ladder_connect_o)
		else $error("ladder connected in stop");
	no_resume_a: assert property ($fell(stop_mode_i) |-> stays_idle)
		else $error("conversion resumed after stop");
	err_decode_a: assert property (pslverr_o == (psel_i && penable_i && !mapped))
		else $error("error response does not match address decode");
endmodule
bind acs_adc_seq acs_adc_seq_sva acs_adc_seq_sva_inst (.mclk_i, .rst_b_i, .psel_i,
	.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pslverr_o, .stop_mode_i,
	.channel_select_o, .analog_input_disable_o, .ladder_connect_o, .busy_o,
	.conv_done_irq_o);

// ===== dv/acs_adc_seq_tb_top.sv
// Register-level bench for the converter sequencer.
// Assumes zero-wait APB and the analog model on the comparator input.
`timescale 1ns/1ps
module acs_adc_seq_tb_top;
	// ****
	// Signals and instances
	// ****
	localparam logic [11:0] A_C1 = {acs_pkg::ACS_IDX_CTRL_ONE, 2'b00};
	localparam logic [11:0] A_C2 = {acs_pkg::ACS_IDX_CTRL_TWO, 2'b00};
	localparam logic [11:0] A_RS = {acs_pkg::ACS_IDX_RESULT, 2'b00};
	localparam logic [11:0] A_ST = {acs_pkg::ACS_IDX_STATUS, 2'b00};
	localparam logic [11:0] A_IS = {acs_pkg::ACS_IDX_IRQ_STAT, 2'b00};
	localparam logic [11:0] A_IC = {acs_pkg::ACS_IDX_IRQ_CLEAR, 2'b00};
	localparam logic [11:0] A_IE = {acs_pkg::ACS_IDX_IRQ_EN, 2'b00};
	logic        mclk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic        stop_mode_i, comp_hi_i, analog_input_disable_o, ladder_connect_o;
	logic        busy_o, conv_done_irq_o, irq_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o;
	logic [7:0]  dac_code_o;
	logic [3:0]  channel_select_o;
	int          err_count, total_checks;
	int          cyc[3] = '{78, 156, 312};
	acs_adc_seq acs_adc_seq_inst (.mclk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .stop_mode_i, .comp_hi_i,
		.dac_code_o, .channel_select_o, .analog_input_disable_o, .ladder_connect_o,
		.busy_o, .conv_done_irq_o, .irq_o);
	acs_ain_model acs_ain_model_inst (.channel_select_i(channel_select_o),
		.dac_code_i(dac_code_o), .ladder_i(ladder_connect_o), .comp_hi_o(comp_hi_i));
	// ****
	// Tasks
	// ****
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic s);
		@(posedge mclk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		@(posedge mclk_i);
		// Waits as long as the slave stalls; only the watchdog ends a hung transfer
		while (pready_o !== 1'b1) begin
			@(posedge mclk_i);
		end
		q = prdata_o;
		s = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		logic        s;
		apb(1'b0, a, 32'h0, q, s);
		chk(q, e);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        s;
		apb(1'b1, a, d, q, s);
	endtask
	task automatic start(input logic [3:0] c, input logic [2:0] t);
		wr(A_C2, {28'h0, t, 1'b0});
		wr(A_C1, {24'h0, 4'h8, c});
	endtask
	// Start is taken one edge after the write and the pulse is seen one edge after it is launched, hence n + 2
	task automatic finish(input int n);
		int k;
		k = 0;
		while (conv_done_irq_o !== 1'b1 && k < 400) begin
			@(posedge mclk_i);
			k++;
		end
		chk(k, n);
	endtask
	function automatic logic [31:0] lvl(input logic [3:0] c);
		return {24'h0, 8'h17 * c + 8'h05};
	endfunction
	// ****
	// Sequence
	// ****
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	initial begin
		#(25 * 10000);
		err_count++;
		complete_run();
	end
	initial begin
		logic [31:0] q;
		logic        s;
		{rst_b_i, psel_i, penable_i, pwrite_i, stop_mode_i} = 5'h00;
		paddr_i = 12'h000;
		pwdata_i = 32'h0;
		repeat (4) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		rd(A_C1, 32'h10);
		rd(A_ST, 32'h0);
		wr(A_IE, 32'h1);
		for (int i = 0; i < 3; i++) begin
			start(4'(i + 2), 3'(i + 2));
			finish(cyc[i] + 2);
			rd(A_C1, 32'(i + 2));
			rd(A_ST, 32'h20);
			chk({31'h0, irq_o}, 32'h1);
			wr(A_IC, 32'h1);
			rd(A_IS, 32'h0);
			rd(A_RS, lvl(4'(i + 2)));
			rd(A_ST, 32'h0);
		end
		wr(A_IE, 32'h0);
		start(4'h2, acs_pkg::ACS_TIME_78);
		finish(80);
		start(4'h5, acs_pkg::ACS_TIME_78);
		rd(A_ST, 32'h10);
		rd(A_RS, lvl(4'h2));
		finish(74);
		rd(A_IS, 32'h1);
		chk({31'h0, irq_o}, 32'h0);
		rd(A_RS, lvl(4'h5));
		apb(1'b0, 12'h100, 32'h0, q, s);
		chk({31'h0, s}, 32'h1);
		chk(q, 32'h0);
		start(4'h3, acs_pkg::ACS_TIME_312);
		repeat (10) @(posedge mclk_i);
		stop_mode_i <= 1'b1;
		wr(A_C1, 32'h83);
		chk({31'h0, busy_o}, 32'h0);
		stop_mode_i <= 1'b0;
		finish(400);
		rd(A_C1, 32'h10);
		rd(A_C2, 32'h0);
		rd(A_RS, 32'h0);
		// Reserved time code with the ladder held on falls back to the longest time
		wr(A_C2, 32'h2e);
		@(posedge mclk_i);
		chk({31'h0, ladder_connect_o}, 32'h1);
		wr(A_C1, 32'h84);
		finish(314);
		rd(A_RS, lvl(4'h4));
		complete_run();
	end
endmodule
